// ==== pkg/mps_cfg.svh ====
// Timing constants and documented default values for the motor PWM and ADC trigger block.
`ifndef MPS_CFG_SVH
`define MPS_CFG_SVH
`define MPS_CLK_MHZ 100
`define MPS_START_DEF 16'hF448
`define MPS_MOD_DEF 16'h0BB7
`define MPS_DEAD_NS 1500
`define MPS_DEAD_CYC ((`MPS_DEAD_NS * `MPS_CLK_MHZ + 999) / 1000)
`define MPS_PRE0_NS (`MPS_DEAD_NS / 2)
`define MPS_PRE0_CYC ((`MPS_PRE0_NS * `MPS_CLK_MHZ + 999) / 1000)
`define MPS_ADC_DIV 4
`define MPS_ADC_TICKS 13
`define MPS_SLOW_DIV 16
`define MPS_SLOW_MULT 10
`define MPS_PWM_USED 6
`endif

// ==== pkg/mps_pkg.sv ====
// Types shared by the motor PWM and ADC trigger block.
package mps_pkg;
  typedef enum logic {MPS_ADC_IDLE, MPS_ADC_CONV} mps_adc_state_t;
  typedef struct packed {
    logic hi;
    logic lo;
    logic cur;
    logic [7:0] cnt;
  } mps_pair_st_t;
  typedef struct packed {
    mps_adc_state_t state;
    logic sel;
    logic [1:0] div;
    logic [3:0] tick;
    logic [11:0] data;
    logic done;
    logic done_sel;
  } mps_adc_st_t;
  typedef struct packed {
    logic signed [15:0] cnt;
    logic fault;
    logic trig_en;
    logic [15:0] pdb_cnt;
    logic run;
    logic pre0_pend;
    logic seq_err;
    logic dly;
    logic [3:0] unread;
    logic [3:0][11:0] res;
    logic fast_irq;
    logic [3:0] slow_pre;
    logic [15:0] slow_cnt;
    logic slow_irq;
  } mps_top_st_t;
endpackage : mps_pkg

// ==== pkg/mps_if.sv ====
// Interfaces between the top and its converter and dead-time pair modules.
`timescale 1ns/100ps
interface mps_adc_if;
  logic start;
  logic sel;
  logic done;
  logic done_sel;
  logic [11:0] result;
  modport ctl (output start, output sel, input done, input done_sel, input result);
  modport conv (input start, input sel, output done, output done_sel, output result);
endinterface : mps_adc_if

interface mps_pair_if;
  logic ref_lvl;
  logic en;
  logic hi;
  logic lo;
  modport ctl (output ref_lvl, output en, input hi, input lo);
  modport pair (input ref_lvl, input en, output hi, output lo);
endinterface : mps_pair_if

// ==== core/mps_dtpair.sv ====
// Complementary output pair with dead-time insertion and fault shutdown.
`timescale 1ns/100ps
`include "mps_cfg.svh"
module mps_dtpair import mps_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  mps_pair_if.pair pb
);
  localparam logic [7:0] DEAD = 8'(`MPS_DEAD_CYC);
  mps_pair_st_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!pb.en || pb.ref_lvl != st_r.cur) begin
      st_nxt.hi = 1'b0;
      st_nxt.lo = 1'b0;
      // The gap spans the load cycle plus the countdown, so one less is loaded.
      st_nxt.cnt = DEAD - 8'h01;
      st_nxt.cur = pb.ref_lvl;
    end else if (st_r.cnt != 8'h00) begin
      st_nxt.cnt = st_r.cnt - 8'h01;
    end else begin
      st_nxt.hi = st_r.cur;
      st_nxt.lo = ~st_r.cur;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{hi: 1'b0, lo: 1'b0, cur: 1'b0, cnt: 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pb.hi = st_r.hi;
  assign pb.lo = st_r.lo;

  never_both_a: assert property (@(posedge clk) disable iff (!rst_n) !(pb.hi && pb.lo))
    else $error("pair drives both outputs");
  dead_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pb.en && pb.ref_lvl != st_r.cur) |=> (!pb.hi && !pb.lo) [*8])
    else $error("dead time gap too short");
  fault_off_a: assert property (@(posedge clk) disable iff (!rst_n) !pb.en |=> !pb.hi && !pb.lo)
    else $error("outputs not off during fault");
endmodule : mps_dtpair

// ==== core/mps_adc.sv ====
// 12-bit converter paced by a divided clock and started only by pre-triggers.
`timescale 1ns/100ps
`include "mps_cfg.svh"
module mps_adc import mps_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0][11:0] sample,
  mps_adc_if.conv ab
);
  localparam logic [1:0] DIV_LAST = 2'(`MPS_ADC_DIV - 1);
  localparam logic [3:0] TICKS = 4'(`MPS_ADC_TICKS);
  mps_adc_st_t st_r, st_nxt;
  logic tick;

  // conversion clock is bus clock over four
  assign tick = st_r.div == DIV_LAST;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.div = st_r.div + 2'h1;
    unique case (st_r.state)
      MPS_ADC_IDLE: begin
        if (ab.start) begin
          st_nxt.state = MPS_ADC_CONV;
          st_nxt.sel = ab.sel;
          st_nxt.data = sample[ab.sel];
          st_nxt.tick = 4'h0;
          st_nxt.div = 2'h0;
        end
      end
      MPS_ADC_CONV: begin
        if (tick) begin
          st_nxt.tick = st_r.tick + 4'h1;
          if (st_r.tick == TICKS - 4'h1) begin
            st_nxt.state = MPS_ADC_IDLE;
            st_nxt.done = 1'b1;
            st_nxt.done_sel = st_r.sel;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{state: MPS_ADC_IDLE, sel: 1'b0, div: 2'h0, tick: 4'h0, data: 12'h000, done: 1'b0, done_sel: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ab.done = st_r.done;
  assign ab.done_sel = st_r.done_sel;
  assign ab.result = st_r.data;

  conv_length_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.state == MPS_ADC_IDLE && ab.start) |=> ##52 ab.done)
    else $error("conversion length wrong");
  start_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.state == MPS_ADC_IDLE && !ab.start) |=> st_r.state == MPS_ADC_IDLE)
    else $error("conversion started without trigger");
endmodule : mps_adc

// ==== core/mps_top.sv ====
// Three-phase PWM timer, trigger-delay block, two converters and slow-loop timer.
`timescale 1ns/100ps
`include "mps_cfg.svh"
module mps_top import mps_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] counter_start_value,
  input wire logic [15:0] counter_modulo,
  input wire logic [2:0][15:0] duty_value,
  input wire logic [7:0] output_mask_control,
  input wire logic fault_enable,
  input wire logic fault_in_n,
  input wire logic trig_on,
  input wire logic trig_off,
  input wire logic [15:0] interrupt_delay_value,
  input wire logic [3:0][11:0] adc_sample,
  input wire logic [3:0] result_read,
  input wire logic seq_err_clear,
  input wire logic delay_clear,
  output logic [7:0] pwm_out,
  output logic reload_trigger,
  output logic [1:0] pre_trigger,
  output logic [3:0][11:0] adc_result,
  output logic [3:0] result_unread,
  output logic fast_loop_irq,
  output logic trig_delay_irq,
  output logic seq_err_flag,
  output logic delay_flag,
  output logic slow_loop_irq,
  output logic trig_enabled,
  output logic [15:0] pwm_count
);
  localparam logic [15:0] PRE0_DLY = 16'(`MPS_PRE0_CYC);
  localparam logic [3:0] SLOW_LAST = 4'(`MPS_SLOW_DIV - 1);

  mps_top_st_t st_r, st_nxt;
  logic reload, fault_act, pre0_fire, slow_tick;
  logic [1:0] adc_done, adc_dsel, pre1_fire;
  logic [1:0][11:0] adc_res;
  logic [5:0] pair_out;
  logic [16:0] span;
  logic [15:0] slow_mod;

  mps_adc_if adc_bus[2] ();
  mps_pair_if pair_bus[3] ();

  ////////////////////////////////////////////////////////////////////////////
  // reload at the modulo value
  assign reload = st_r.cnt >= $signed(counter_modulo);
  assign fault_act = fault_enable && !fault_in_n;
  assign reload_trigger = reload && st_r.trig_en;
  // pre-trigger 0 after half a dead time
  assign pre0_fire = st_r.run && st_r.pre0_pend && st_r.pdb_cnt == PRE0_DLY;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pair
      assign pair_bus[g].ref_lvl = st_r.cnt < $signed(duty_value[g]);
      // pair disabled while fault holds or until reload
      assign pair_bus[g].en = !st_r.fault && !fault_act;
      assign pair_out[2 * g] = pair_bus[g].hi;
      assign pair_out[2 * g + 1] = pair_bus[g].lo;
      mps_dtpair u_pair (
        .clk(clk),
        .rst_n(rst_n),
        .pb(pair_bus[g])
      );
    end
    for (g = 0; g < 2; g++) begin : g_adc
      assign adc_done[g] = adc_bus[g].done;
      assign adc_dsel[g] = adc_bus[g].done_sel;
      assign adc_res[g] = adc_bus[g].result;
      // back-to-back start of the second conversion
      assign pre1_fire[g] = adc_done[g] && !adc_dsel[g];
      assign adc_bus[g].start = pre0_fire || pre1_fire[g];
      assign adc_bus[g].sel = !pre0_fire;
      mps_adc u_adc (
        .clk(clk),
        .rst_n(rst_n),
        .sample(adc_sample[2 * g + 1 -: 2]),
        .ab(adc_bus[g])
      );
    end
  endgenerate

  assign pwm_out = {2'b00, pair_out} & ~output_mask_control;
  assign pre_trigger = {|pre1_fire, pre0_fire};

  // slow period derived from the PWM modulo and start value
  assign span = 17'($signed(counter_modulo) - $signed(counter_start_value)) + 17'h0_0001;
  assign slow_mod = 16'(17'(span[16:4]) * 17'(`MPS_SLOW_MULT));
  assign slow_tick = st_r.slow_pre == SLOW_LAST;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.cnt = reload ? $signed(counter_start_value) : st_r.cnt + 16'sh0001;
    st_nxt.fault = fault_act ? 1'b1 : (reload ? 1'b0 : st_r.fault);
    // enabled by default; software toggles it
    if (trig_off) begin
      st_nxt.trig_en = 1'b0;
    end
    if (trig_on) begin
      st_nxt.trig_en = 1'b1;
    end
    // delay counter on the same clock
    if (st_r.run && st_r.pdb_cnt != 16'hFFFF) begin
      st_nxt.pdb_cnt = st_r.pdb_cnt + 16'h0001;
    end
    if (pre0_fire) begin
      st_nxt.pre0_pend = 1'b0;
    end
    if (reload_trigger) begin
      st_nxt.pdb_cnt = 16'h0000;
      st_nxt.run = 1'b1;
      st_nxt.pre0_pend = 1'b1;
    end
    if (delay_clear) begin
      st_nxt.dly = 1'b0;
    end
    if (st_r.run && st_r.pdb_cnt == interrupt_delay_value) begin
      st_nxt.dly = 1'b1;
    end
    st_nxt.unread = st_r.unread & ~result_read;
    if (seq_err_clear) begin
      st_nxt.seq_err = 1'b0;
    end
    if ((pre0_fire && (st_r.unread[0] || st_r.unread[2])) || (pre1_fire[0] && st_r.unread[1])
        || (pre1_fire[1] && st_r.unread[3])) begin
      st_nxt.seq_err = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      if (adc_done[i]) begin
        st_nxt.res[2 * i + int'(adc_dsel[i])] = adc_res[i];
        st_nxt.unread[2 * i + int'(adc_dsel[i])] = 1'b1;
      end
    end
    // fast-loop interrupt on first conversion complete
    st_nxt.fast_irq = pre1_fire[0];
    st_nxt.slow_pre = st_r.slow_pre + 4'h1;
    st_nxt.slow_irq = 1'b0;
    if (slow_tick) begin
      if (st_r.slow_cnt >= slow_mod) begin
        st_nxt.slow_cnt = 16'h0000;
        st_nxt.slow_irq = 1'b1;
      end else begin
        st_nxt.slow_cnt = st_r.slow_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{cnt: 16'sh0000, fault: 1'b0, trig_en: 1'b1, pdb_cnt: 16'h0000, run: 1'b0,
                pre0_pend: 1'b0, seq_err: 1'b0, dly: 1'b0, unread: 4'h0, res: '0, fast_irq: 1'b0,
                slow_pre: 4'h0, slow_cnt: 16'h0000, slow_irq: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign trig_delay_irq = st_r.seq_err || st_r.dly;
  assign seq_err_flag = st_r.seq_err;
  assign delay_flag = st_r.dly;
  assign adc_result = st_r.res;
  assign result_unread = st_r.unread;
  assign fast_loop_irq = st_r.fast_irq;
  assign slow_loop_irq = st_r.slow_irq;
  assign trig_enabled = st_r.trig_en;
  assign pwm_count = st_r.cnt;

  ////////////////////////////////////////////////////////////////////////////
  counter_reload_a: assert property (@(posedge clk) disable iff (!rst_n)
    reload |=> st_r.cnt == $signed($past(counter_start_value)))
    else $error("counter did not reload to start value");
  mask_hold_a: assert property (@(posedge clk) disable iff (!rst_n) pwm_out[7:6] == 2'b00)
    else $error("unused channel active");
  fault_recover_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.fault && !fault_act && !reload) |=> st_r.fault)
    else $error("fault cleared before reload");
  trig_at_reload_a: assert property (@(posedge clk) disable iff (!rst_n)
    reload_trigger |-> reload && st_r.trig_en)
    else $error("trigger off reload");
  delay_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    reload_trigger |=> st_r.pdb_cnt == 16'h0000 && st_r.run)
    else $error("delay counter not restarted");
  pre0_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reload_trigger && !trig_on && !trig_off) |-> ##76 pre0_fire)
    else $error("pre-trigger 0 late or missing");
  back_to_back_a: assert property (@(posedge clk) disable iff (!rst_n)
    (adc_done[0] && !adc_dsel[0]) |-> adc_bus[0].start && adc_bus[0].sel)
    else $error("pre-trigger 1 not immediate");
  seq_error_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pre0_fire && st_r.unread[0]) |=> st_r.seq_err)
    else $error("sequence error missed");
  delay_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.run && st_r.pdb_cnt == interrupt_delay_value) |=> trig_delay_irq && st_r.dly)
    else $error("delay interrupt missed");
  fast_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(fast_loop_irq) |-> $past(adc_done[0]) && !$past(adc_dsel[0]))
    else $error("fast interrupt without conversion");
  slow_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    slow_loop_irq |-> st_r.slow_cnt == 16'h0000 && st_r.slow_pre == 4'h0)
    else $error("slow interrupt misplaced");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the flags, counters, conversion sequencing and results, the trigger gate and the output gating that software relies on.
  fault_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fault_enable && !fault_in_n) |=> pwm_out[5:0] == 6'h00)
    else $error("outputs live during enabled fault");
  fault_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    fault_act |=> st_r.fault)
    else $error("fault not latched");
  fault_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.fault && !fault_act && reload) |=> !st_r.fault)
    else $error("fault not released at reload");
  counter_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    !reload |=> st_r.cnt == $past(st_r.cnt) + 16'sh0001)
    else $error("counter did not step by one");
  trig_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    (trig_off && !trig_on) |=> !trig_enabled)
    else $error("trigger not disabled");
  trig_on_a: assert property (@(posedge clk) disable iff (!rst_n)
    trig_on |=> trig_enabled)
    else $error("trigger not re-enabled");
  trig_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!trig_on && !trig_off) |=> trig_enabled == $past(trig_enabled))
    else $error("trigger enable changed by itself");
  pre0_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pre0_fire && !reload_trigger) |=> !st_r.pre0_pend)
    else $error("pre-trigger 0 still pending");
  adc1_b2b_a: assert property (@(posedge clk) disable iff (!rst_n)
    (adc_done[1] && !adc_dsel[1]) |-> adc_bus[1].start && adc_bus[1].sel)
    else $error("second converter missed pre-trigger 1");
  result_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    (adc_done[0] && !adc_dsel[0]) |=> adc_result[0] == $past(adc_res[0]) && result_unread[0])
    else $error("phase result not stored");
  bus_result_a: assert property (@(posedge clk) disable iff (!rst_n)
    (adc_done[1] && adc_dsel[1]) |=> adc_result[3] == $past(adc_res[1]) && result_unread[3])
    else $error("bus result not stored");
  seq_pre1_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pre1_fire[0] && st_r.unread[1]) |=> st_r.seq_err)
    else $error("sequence error missed on pre-trigger 1");
  seq_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.seq_err && !seq_err_clear) |=> st_r.seq_err)
    else $error("sequence error lost");
  unread_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (result_read[2] && !(adc_done[1] && !adc_dsel[1])) |=> !result_unread[2])
    else $error("read did not clear unread bit");
  delay_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.dly && !delay_clear) |=> st_r.dly)
    else $error("delay flag lost");
  delay_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (delay_clear && !(st_r.run && st_r.pdb_cnt == interrupt_delay_value)) |=> !delay_flag)
    else $error("delay flag not cleared");
  delay_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.run && !reload_trigger && st_r.pdb_cnt != 16'hFFFF) |=> st_r.pdb_cnt == $past(st_r.pdb_cnt) + 16'h0001)
    else $error("delay counter skipped");
  fast_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    fast_loop_irq |=> !fast_loop_irq)
    else $error("fast interrupt longer than one cycle");
  slow_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    slow_loop_irq |=> !slow_loop_irq)
    else $error("slow interrupt longer than one cycle");
  slow_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
    slow_loop_irq |-> $past(st_r.slow_pre) == SLOW_LAST)
    else $error("slow interrupt off prescaler tick");
  mask_apply_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pwm_out & output_mask_control) == 8'h00)
    else $error("masked channel active");
  pair_comp_a: assert property (@(posedge clk) disable iff (!rst_n)
    pwm_out[1:0] != 2'b11 && pwm_out[3:2] != 2'b11 && pwm_out[5:4] != 2'b11)
    else $error("pair output shoot-through");
endmodule : mps_top

// ==== verif/mps_plant.sv ====
// Far-side model: converter analog inputs and gate drivers of the inverter.
`timescale 1ns/100ps
module mps_plant (
  input wire logic clk,
  input wire logic [7:0] gate,
  input wire logic [3:0][11:0] level,
  output logic [3:0][11:0] adc_sample,
  output int shoot_cnt
);
  assign adc_sample = level;
  initial shoot_cnt = 0;
  always @(negedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (gate[2*i] === 1'b1 && gate[2*i+1] === 1'b1) begin
        shoot_cnt = shoot_cnt + 1;
      end
    end
    if (gate[7:6] !== 2'b00) begin
      shoot_cnt = shoot_cnt + 1;
    end
  end
endmodule : mps_plant

// ==== verif/testbench.sv ====
// Self-checking bench for the motor PWM and ADC trigger block.
`timescale 1ns/100ps
module testbench import mps_pkg::*; ;
  logic clk = 0;
  logic rst_n = 0;
  logic [15:0] idly = 16'hffff;
  logic [2:0][15:0] duty = {16'h0064, 16'h0000, 16'h0064};
  logic [7:0] mask = 8'hc0;
  logic f_en = 1, f_n = 1, t_on = 0, t_off = 0, se_clr = 0, d_clr = 0;
  logic [3:0] rd = 0, unr;
  logic [3:0][11:0] lvl = 0, smp, res;
  logic [7:0] pwm, seen = 0;
  logic [1:0] pre;
  logic rtrig, firq, dirq, seflag, dflag, sirq, ten;
  logic [15:0] pcnt;
  logic [9:0] ev;
  int bad_count = 0, n_tests = 0, shoot, n, k;
  integer seed = 32'h906a_0236;
  logic [23:0] q[$];

  assign ev = {pwm[1], ~pwm[0], sirq, dflag, seflag, firq, pre, rtrig, pwm[0]};
  always #5 clk = ~clk;
  always @(posedge clk) seen <= seen | pwm;

  mps_top uut (.clk(clk), .rst_n(rst_n), .counter_start_value(16'hfed4), .counter_modulo(16'h012b),
    .duty_value(duty), .output_mask_control(mask), .fault_enable(f_en), .fault_in_n(f_n), .trig_on(t_on),
    .trig_off(t_off), .interrupt_delay_value(idly), .adc_sample(smp), .result_read(rd),
    .seq_err_clear(se_clr), .delay_clear(d_clr), .pwm_out(pwm), .reload_trigger(rtrig), .pre_trigger(pre),
    .adc_result(res), .result_unread(unr), .fast_loop_irq(firq), .trig_delay_irq(dirq),
    .seq_err_flag(seflag), .delay_flag(dflag), .slow_loop_irq(sirq), .trig_enabled(ten), .pwm_count(pcnt));
  mps_plant plant (.clk(clk), .gate(pwm), .level(lvl), .adc_sample(smp), .shoot_cnt(shoot));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v);
    n_tests++;
    if (seen_v !== exp_v) begin
      bad_count++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen_v, exp_v);
    end
  endtask : check

  task tick(input int c);
    repeat (c) @(negedge clk);
  endtask : tick

  // Returns in n the cycles until event bit b is seen, bounded by lim.
  task wait_ev(input int b, input int lim);
    n = 1;
    @(negedge clk);
    while (ev[b] !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_ev

  task automatic pulse(ref logic s);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask : pulse

  task rd_all;
    rd = 4'hf;
    @(negedge clk);
    rd = 4'h0;
  endtask : rd_all

  task period(input bit do_read);
    for (int i = 0; i < 4; i++) begin
      lvl[i] = 12'($random(seed));
    end
    q.push_back({lvl[0], lvl[2]});
    wait_ev(1, 700);
    wait_ev(2, 100);
    check(16'(n), 16'd76);
    wait_ev(3, 100);
    check(16'(n), 16'd53);
    wait_ev(4, 5);
    check(16'(n), 16'd1);
    check(16'({unr[2], unr[0]}), 16'h0003);
    tick(60);
    check(16'(res[1]), 16'(lvl[1]));
    check(16'(res[3]), 16'(lvl[3]));
    if (do_read) begin
      rd_all;
    end
  endtask : period

  task end_of_test;
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////
  // Phase-current results are compared when the fast-loop pulse shows.
  always @(negedge clk) begin
    if (firq === 1'b1 && q.size() > 0) begin
      check(16'(res[0]), 16'(q[0][23:12]));
      check(16'(res[2]), 16'(q[0][11:0]));
      void'(q.pop_front());
    end
  end

  initial begin
    #400_000;
    bad_count++;
    end_of_test;
  end

  initial begin
    tick(4);
    check(16'({ten, seflag, dflag, pwm}), 16'h0400);
    rst_n = 1;
    wait_ev(1, 700);
    check(pcnt, 16'h012b);
    wait_ev(1, 700);
    check(16'(n), 16'd600);
    $display("period test done");
    tick(200);
    rd_all;
    pulse(se_clr);
    period(1);
    period(0);
    check(16'(seflag), 16'h0000);
    period(1);
    check(16'({dirq, seflag}), 16'h0003);
    pulse(se_clr);
    check(16'({dirq, seflag}), 16'h0000);
    $display("conversion test done");
    idly = 16'h012c;
    wait_ev(1, 700);
    pulse(d_clr);
    wait_ev(6, 400);
    check(16'(n), 16'd301);
    check(16'({dirq, seflag}), 16'h0002);
    rd_all;
    pulse(d_clr);
    idly = 16'hffff;
    $display("delay test done");
    pulse(t_off);
    check(16'(ten), 16'h0000);
    k = 0;
    repeat (1300) begin
      @(negedge clk);
      if (rtrig === 1'b1 || pre[0] === 1'b1) begin
        k++;
      end
    end
    check(16'(k), 16'h0000);
    pulse(t_on);
    check(16'(ten), 16'h0001);
    wait_ev(1, 700);
    check(16'(n <= 600), 16'h0001);
    tick(200);
    rd_all;
    $display("trigger gate test done");
    mask = 8'h3c;
    seen = 0;
    tick(600);
    check(16'(seen), 16'h0003);
    mask = 8'h00;
    seen = 0;
    tick(600);
    check(16'(seen), 16'h003f);
    wait_ev(0, 700);
    wait_ev(8, 700);
    wait_ev(9, 700);
    check(16'(n), 16'd150);
    $display("output test done");
    f_n = 0;
    tick(1);
    check(16'(pwm), 16'h0000);
    seen = 0;
    tick(700);
    check(16'(seen), 16'h0000);
    wait_ev(1, 700);
    tick(100);
    f_n = 1;
    seen = 0;
    wait_ev(1, 700);
    check(16'(seen), 16'h0000);
    seen = 0;
    tick(600);
    check(16'(seen), 16'h003f);
    f_en = 0;
    f_n = 0;
    seen = 0;
    tick(600);
    check(16'(seen), 16'h003f);
    f_n = 1;
    f_en = 1;
    $display("fault test done");
    wait_ev(7, 7000);
    wait_ev(7, 7000);
    check(16'(n), 16'd5936);
    check(16'(shoot), 16'h0000);
    $display("slow loop test done");
    end_of_test;
  end
endmodule : testbench
